/* logic/ecbs_buf2.v */
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module ecbs_buf2 #(
  parameter WIDTH = 32
) (
  // Clock and reset
  input  wire             clk_sys_i,
  input  wire             rstn_i,
  // Fill side
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  // Drain side
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] slot0_ff;
  reg [WIDTH-1:0] slot1_ff;
  reg [1:0]       cnt_ff;
  wire            push;
  wire            pop;

  assign in_ready_o  = (cnt_ff != 2'h2);
  assign out_valid_o = (cnt_ff != 2'h0);
  assign out_data_o  = slot0_ff;
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      slot0_ff <= {WIDTH{1'b0}};
      slot1_ff <= {WIDTH{1'b0}};
      cnt_ff   <= 2'h0;
    end else begin
      // Head always sits in slot0 so the output is a flop
      if (pop) begin
        slot0_ff <= (cnt_ff == 2'h2) ? slot1_ff : in_data_i;
        if (push && cnt_ff == 2'h2)
          slot1_ff <= in_data_i;
      end else if (push) begin
        if (cnt_ff == 2'h0)
          slot0_ff <= in_data_i;
        else
          slot1_ff <= in_data_i;
      end
      cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

/* logic/ecbs_consts.vh */
// Constants for the external core boot sequencer
`ifndef ECBS_CONSTS_VH
`define ECBS_CONSTS_VH
`define ECBS_ADDR_W        2
`define ECBS_OFF_DATA      2'h0
`define ECBS_OFF_DIR       2'h1
`define ECBS_OFF_MASK      2'h2
`define ECBS_OFF_EDGE      2'h3
`define ECBS_HOLD_RST      1'h0
`define ECBS_EDGE_RST      1'h0
`define ECBS_OP_POS        0
`define ECBS_OP_W          6
`define ECBS_OP_JUMP       6'h06
`define ECBS_DISP_POS      6
`define ECBS_DISP_W        16
`define ECBS_INSN_W        32
`define ECBS_BRANCH_ADJ    32'h00000004
`define ECBS_ACK_PERIOD    8
`define ECBS_DRAIN_CYC     3
`endif

/* logic/ecbs_top.v */
// Device side of the external core boot sequencer: hold PIO, core reset handshake, boot fetch
`timescale 1ns/1ps
`include "ecbs_consts.vh"

module ecbs_top #(
  parameter ADDR_W     = 16,
  parameter [ADDR_W-1:0] RESET_ADDR = {ADDR_W{1'b0}},
  parameter ACK_PERIOD = `ECBS_ACK_PERIOD,
  parameter DRAIN_CYC  = `ECBS_DRAIN_CYC
) (
  // Clock and reset
  input  wire              clk_sys_i,
  input  wire              rstn_i,
  // PIO register port
  input  wire [1:0]        pio_addr_i,
  input  wire              pio_wr_i,
  input  wire              pio_rd_i,
  input  wire [31:0]       pio_wdata_i,
  output wire [31:0]       pio_rdata_o,
  // Host access to program memory
  input  wire              mem_wr_i,
  input  wire [ADDR_W-1:0] mem_addr_i,
  input  wire [31:0]       mem_wdata_i,
  // Core fetch stream
  output wire              fetch_valid_o,
  input  wire              fetch_ready_i,
  output wire [31:0]       fetch_insn_o,
  output wire [ADDR_W-1:0] fetch_pc_o,
  // Core status
  output wire              core_held_o,
  output wire              hold_request_o,
  output wire              hold_ack_o
);
  // ****************************************
  // Core states
  // ****************************************
  localparam [1:0] ST_RUN   = 2'h0;
  localparam [1:0] ST_DRAIN = 2'h1;
  localparam [1:0] ST_HELD  = 2'h2;
  localparam [1:0] ST_BOOT  = 2'h3;

  reg              hold_ff;
  reg              edge_ff;
  reg              mask_ff;
  reg              ack_ff;
  reg              ack_prev_ff;
  reg [31:0]       rdata_ff;
  reg [1:0]        st_ff;
  reg [1:0]        nxt_st;
  reg [7:0]        cnt_ff;
  reg [7:0]        nxt_cnt;
  reg [ADDR_W-1:0] pc_ff;
  reg [ADDR_W-1:0] nxt_pc;
  reg              jumped_ff;
  reg [31:0]       mem [0:(1<<ADDR_W)-1];
  reg [31:0]       rd_word_ff;
  reg [ADDR_W-1:0] rd_pc_ff;
  reg              rd_vld_ff;
  wire             buf_in_ready;
  wire [ADDR_W+31:0] buf_out;
  wire             ack_rise;
  wire             fetch_go;
  wire [15:0]      disp;
  wire [ADDR_W+13:0] disp_words;
  wire             take_jump;

  // ****************************************
  // PIO registers
  // ****************************************
  assign ack_rise = ack_ff & ~ack_prev_ff;

  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hold_ff     <= `ECBS_HOLD_RST;
      edge_ff     <= `ECBS_EDGE_RST;
      mask_ff     <= 1'b0;
      ack_prev_ff <= 1'b0;
      rdata_ff    <= 32'h00000000;
    end else begin
      ack_prev_ff <= ack_ff;
      if (pio_wr_i && pio_addr_i == `ECBS_OFF_DATA)
        hold_ff <= pio_wdata_i[0];
      if (pio_wr_i && pio_addr_i == `ECBS_OFF_MASK)
        mask_ff <= pio_wdata_i[0];
      // Set beats a simultaneous clear so no acknowledge is lost
      if (ack_rise)
        edge_ff <= 1'b1;
      else if (pio_wr_i && pio_addr_i == `ECBS_OFF_EDGE)
        edge_ff <= 1'b0;
      if (pio_rd_i) begin
        if (pio_addr_i == `ECBS_OFF_DATA)
          rdata_ff <= {31'h00000000, ack_ff};
        else if (pio_addr_i == `ECBS_OFF_DIR)
          rdata_ff <= 32'h00000000;
        else if (pio_addr_i == `ECBS_OFF_MASK)
          rdata_ff <= {31'h00000000, mask_ff};
        else
          rdata_ff <= {31'h00000000, edge_ff};
      end
    end
  end

  assign pio_rdata_o    = rdata_ff;
  // Top-level wiring of output bit to request input
  assign hold_request_o = hold_ff;
  assign hold_ack_o     = ack_ff;
  assign core_held_o    = (st_ff == ST_HELD);

  // ****************************************
  // Core reset handshake
  // ****************************************
  always @* begin
    nxt_st  = st_ff;
    nxt_cnt = cnt_ff;
    case (st_ff)
      ST_RUN: begin
        if (hold_ff) begin
          nxt_st  = ST_DRAIN;
          nxt_cnt = 8'h00;
        end
      end
      ST_DRAIN: begin
        // In-flight instructions finish before reset is taken
        nxt_cnt = cnt_ff + 8'h01;
        if (cnt_ff == DRAIN_CYC[7:0]) begin
          nxt_st  = ST_HELD;
          nxt_cnt = 8'h00;
        end
      end
      ST_HELD: begin
        nxt_cnt = (cnt_ff == ACK_PERIOD[7:0] - 8'h01) ? 8'h00 : cnt_ff + 8'h01;
        if (!hold_ff)
          nxt_st = ST_BOOT;
      end
      default: begin
        nxt_cnt = 8'h00;
        if (hold_ff)
          nxt_st = ST_DRAIN;
      end
    endcase
  end

  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff  <= ST_HELD;
      cnt_ff <= 8'h00;
      ack_ff <= 1'b0;
    end else begin
      st_ff  <= nxt_st;
      cnt_ff <= nxt_cnt;
      ack_ff <= (st_ff == ST_HELD) && hold_ff && (cnt_ff == 8'h00);
    end
  end

  // ****************************************
  // Program memory and fetch
  // ****************************************
  // Host writes land only while held; earlier writes would race the core
  always @(posedge clk_sys_i) begin
    if (mem_wr_i && st_ff == ST_HELD)
      mem[mem_addr_i] <= mem_wdata_i;
  end

  assign fetch_go = (st_ff == ST_BOOT) && buf_in_ready && !rd_vld_ff;
  assign disp     = rd_word_ff[`ECBS_DISP_POS +: `ECBS_DISP_W];
  // Signed byte displacement turned into a word step; backward jumps stay correct
  assign disp_words = {{ADDR_W{disp[15]}}, disp[15:2]};
  assign take_jump  = (st_ff == ST_BOOT) && rd_vld_ff && buf_in_ready && !jumped_ff &&
                      (rd_word_ff[`ECBS_OP_POS +: `ECBS_OP_W] == `ECBS_OP_JUMP);

  always @* begin
    nxt_pc = pc_ff;
    if (st_ff == ST_HELD)
      nxt_pc = RESET_ADDR;
    else if (rd_vld_ff && buf_in_ready) begin
      // Displacement is in bytes relative to the next word
      if (take_jump)
        nxt_pc = rd_pc_ff + 1'b1 + disp_words[ADDR_W-1:0];
      else
        nxt_pc = rd_pc_ff + 1'b1;
    end
  end

  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pc_ff      <= {ADDR_W{1'b0}};
      rd_word_ff <= 32'h00000000;
      rd_pc_ff   <= {ADDR_W{1'b0}};
      rd_vld_ff  <= 1'b0;
      jumped_ff  <= 1'b0;
    end else begin
      pc_ff <= nxt_pc;
      if (st_ff != ST_BOOT) begin
        rd_vld_ff <= 1'b0;
        jumped_ff <= 1'b0;
      end else begin
        // Only the first jump after release redirects
        if (take_jump)
          jumped_ff <= 1'b1;
        if (fetch_go) begin
          rd_word_ff <= mem[pc_ff];
          rd_pc_ff   <= pc_ff;
          rd_vld_ff  <= 1'b1;
        end else if (buf_in_ready) begin
          rd_vld_ff <= 1'b0;
        end
      end
    end
  end

  ecbs_buf2 #(
    .WIDTH (ADDR_W + 32)
  ) u_buf (
    .clk_sys_i   (clk_sys_i),
    .rstn_i      (rstn_i),
    .in_valid_i  (rd_vld_ff),
    .in_ready_o  (buf_in_ready),
    .in_data_i   ({rd_pc_ff, rd_word_ff}),
    .out_valid_o (fetch_valid_o),
    .out_ready_i (fetch_ready_i),
    .out_data_o  (buf_out)
  );

  assign fetch_insn_o = buf_out[31:0];
  assign fetch_pc_o   = buf_out[ADDR_W+31:32];
endmodule

/* test/ecbs_sink.sv */
// Fetch consumer standing in for the core's execute stage
`timescale 1ns/1ps
module ecbs_sink (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rstn_i,
  // Fetch stream
  input  wire logic        slow_i,
  input  wire logic        fetch_valid_i,
  input  wire logic [31:0] fetch_insn_i,
  input  wire logic [7:0]  fetch_pc_i,
  output logic             fetch_ready_o,
  // Last accepted word
  output logic             got_o,
  output logic [31:0]      got_insn_o,
  output logic [7:0]       got_pc_o
);
  // Slow mode stalls every other cycle to load the buffer
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fetch_ready_o <= 1'h0;
      got_o <= 1'h0;
    end else begin
      got_o <= fetch_valid_i && fetch_ready_o;
      if (fetch_valid_i && fetch_ready_o) begin
        got_insn_o <= fetch_insn_i;
        got_pc_o <= fetch_pc_i;
      end
      fetch_ready_o <= slow_i ? !fetch_ready_o : 1'h1;
    end
  end
endmodule

/* test/ecbs_top_bench.sv */
// Testbench for the boot sequencer
`timescale 1ns/1ps
module ecbs_top_bench;
  logic clk_sys_i = 0, rstn_i = 0, pio_wr_i = 0, pio_rd_i = 0, mem_wr_i = 0, slow = 0;
  logic [1:0] pio_addr_i = 0;
  logic [31:0] pio_wdata_i = 0, mem_wdata_i = 0, pio_rdata_o, fetch_insn_o, got_insn, rd, br;
  logic [7:0] mem_addr_i = 0, fetch_pc_o, got_pc;
  logic fetch_valid_o, fetch_ready_i, core_held_o, hold_request_o, hold_ack_o, got;
  int errors = 0, checks_done = 0;
  // Entry byte address beside the word address fetched after the jump
  logic [31:0] rows [3][2] = '{'{32'h4, 32'h1}, '{32'h40, 32'h10}, '{32'h3FC, 32'hFF}};
  ecbs_top #(.ADDR_W(8)) dut (.clk_sys_i, .rstn_i, .pio_addr_i, .pio_wr_i, .pio_rd_i, .pio_wdata_i,
    .pio_rdata_o, .mem_wr_i, .mem_addr_i, .mem_wdata_i, .fetch_valid_o, .fetch_ready_i, .fetch_insn_o,
    .fetch_pc_o, .core_held_o, .hold_request_o, .hold_ack_o);
  ecbs_sink u_sink (.clk_sys_i, .rstn_i, .slow_i(slow), .fetch_valid_i(fetch_valid_o),
    .fetch_insn_i(fetch_insn_o), .fetch_pc_i(fetch_pc_o), .fetch_ready_o(fetch_ready_i),
    .got_o(got), .got_insn_o(got_insn), .got_pc_o(got_pc));
  initial forever #20 clk_sys_i = ~clk_sys_i;
  // ****************
  // Tasks
  // ****************
  task check(input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task pio(input logic wr, input logic [1:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    pio_addr_i <= a;
    pio_wdata_i <= d;
    pio_wr_i <= wr;
    pio_rd_i <= !wr;
    @(posedge clk_sys_i);
    pio_wr_i <= 0;
    pio_rd_i <= 0;
    #1 rd = pio_rdata_o;
  endtask
  task mem(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    mem_wr_i <= 1;
    mem_addr_i <= a;
    mem_wdata_i <= d;
    @(posedge clk_sys_i);
    mem_wr_i <= 0;
  endtask
  task fetch(input logic [7:0] pc, input logic [31:0] insn);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      #1 n++;
    end while (!got && n < 100);
    check(got, 32'h1);
    check(got_pc, pc);
    check(got_insn, insn);
  endtask
  task boot(input logic [31:0] entry, pc, input logic wr);
    int n;
    pio(1, 2'h3, 32'h5A);
    pio(1, 2'h0, 32'h1);
    check(hold_request_o, 32'h1);
    n = 0;
    do begin
      pio(0, 2'h3, 32'h0);
      n++;
    end while (rd[0] !== 1'b1 && n < 40);
    check(rd, 32'h1);
    check(core_held_o, 32'h1);
    if (wr) begin
      // Known fill keeps later stray fetches defined
      for (int k = 0; k < 256; k++) mem(k[7:0], 32'h00000000);
      br = {10'h0, entry[15:0] - 16'h4, 6'h06};
      mem(8'h0, br);
      mem(entry[9:2], 32'hC0DE0000 | entry);
    end
    pio(1, 2'h0, 32'h0);
    fetch(8'h0, br);
    fetch(pc[7:0], 32'hC0DE0000 | entry);
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ****************
  // Sequence
  // ****************
  initial begin
    repeat (8) @(posedge clk_sys_i);
    rstn_i <= 1;
    #1 check(hold_request_o, 32'h0);
    check(core_held_o, 32'h1);
    check(fetch_valid_o, 32'h0);
    foreach (rows[i]) boot(rows[i][0], rows[i][1], 1);
    // A write while the core runs is dropped, so the old jump stays
    repeat (4) @(posedge clk_sys_i);
    check(core_held_o, 32'h0);
    mem(8'h0, 32'hFFFFFFFF);
    slow <= 1;
    boot(32'h3FC, 32'hFF, 0);
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    errors++;
    give_verdict();
  end
endmodule

/* test/ecbs_top_monitor.sv */
// Port checker for the boot sequencer
`timescale 1ns/1ps
module ecbs_chk (
  // Clock and reset
  input wire logic        clk_sys_i,
  input wire logic        rstn_i,
  // PIO writes
  input wire logic [1:0]  pio_addr_i,
  input wire logic        pio_wr_i,
  input wire logic [31:0] pio_wdata_i,
  // Fetch and status
  input wire logic        fetch_valid_o,
  input wire logic        fetch_ready_i,
  input wire logic [31:0] fetch_insn_o,
  input wire logic        core_held_o,
  input wire logic        hold_request_o,
  input wire logic        hold_ack_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  // ****************
  // Properties
  // ****************
  property p_req_set; pio_wr_i && pio_addr_i == 2'h0 && pio_wdata_i[0] |=> hold_request_o; endproperty
  property p_req_clr; pio_wr_i && pio_addr_i == 2'h0 && !pio_wdata_i[0] |=> !hold_request_o; endproperty
  property p_ack_one; hold_ack_o |=> !hold_ack_o; endproperty
  property p_ack_held; hold_ack_o |-> $past(hold_request_o); endproperty
  // Acknowledge keeps coming back while the request stands
  property p_ack_rep; hold_ack_o |-> ##[1:8] (hold_ack_o || !hold_request_o); endproperty
  property p_ack_first; $rose(hold_request_o) |-> ##[1:24] (hold_ack_o || !hold_request_o); endproperty
  property p_release; $fell(hold_request_o) |-> ##[1:8] !core_held_o; endproperty
  property p_stall; fetch_valid_o && !fetch_ready_i |=> fetch_valid_o && $stable(fetch_insn_o); endproperty
  a_req_set: assert property (p_req_set) else $error("hold request not raised");
  a_req_clr: assert property (p_req_clr) else $error("hold request not dropped");
  a_ack_one: assert property (p_ack_one) else $error("acknowledge longer than one cycle");
  a_ack_held: assert property (p_ack_held) else $error("acknowledge without request");
  a_ack_rep: assert property (p_ack_rep) else $error("acknowledge not repeated");
  a_ack_first: assert property (p_ack_first) else $error("no acknowledge after request");
  a_release: assert property (p_release) else $error("core not released");
  a_stall: assert property (p_stall) else $error("fetch word lost in stall");
  c_ack: cover property (hold_ack_o);
  c_stall: cover property (fetch_valid_o && !fetch_ready_i);
  c_rel: cover property ($fell(hold_request_o));
endmodule
bind ecbs_top ecbs_chk u_chk (.clk_sys_i, .rstn_i, .pio_addr_i, .pio_wr_i, .pio_wdata_i, .fetch_valid_o,
  .fetch_ready_i, .fetch_insn_o, .core_held_o, .hold_request_o, .hold_ack_o);
